// file: src/iomge_core.sv
// execution block for increment, skip, jump, or and move instructions
//
// Overview of operation
// RQ1: increment-skip adds one, zero result skips next
// RQ2: increment-skip destination bit chooses accumulator or file
// RQ3: jump loads immediate and page latch bits 4:3
// RQ4: jump takes two cycles, flags untouched
// RQ5: or-literal ors accumulator, result accumulator, zero flag
// RQ6: increment adds one, routes by destination, zero flag
// RQ7: or-file ors accumulator with file, routes, zero
// RQ8: move copies file to accumulator or back itself
// RQ9: move updates zero flag from moved value
// RQ10: zero set on zero result; others single cycle
`default_nettype none
module iomge_core (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // instruction from fetch
   input  wire logic        insn_valid,
   input  wire logic [13:0] insn_word,
   output logic             insn_ready,
   // register file read port
   output logic [6:0]       file_raddr,
   input  wire logic [7:0]  file_rdata,
   // register file write port
   output logic             file_we,
   output logic [6:0]       file_waddr,
   output logic [7:0]       file_wdata,
   // page latch from core
   input  wire logic [7:0]  page_latch,
   // core state
   output logic [7:0]       acc_q,
   output logic             zero_flag_q,
   output logic [12:0]      program_counter_q,
   output logic             busy_q
);
   // ==========================================================
   // decode
   // the jump opcode only uses the top three bits, so it is tested first;
   // every other pattern needs the full six-bit opcode field.
   // anything not listed decodes to none and just steps the counter.
   function automatic iomge_pkg::iomge_op_t decode(input logic [13:0] w);
      iomge_pkg::iomge_op_t op;
      op = iomge_pkg::IOMGE_OP_NONE;
      if (w[13:11] == iomge_pkg::OPC_JUMP) begin
         op = iomge_pkg::IOMGE_OP_JUMP_ABSOLUTE;
      end else if (w[13:8] == iomge_pkg::OPC_OR_LIT) begin
         op = iomge_pkg::IOMGE_OP_OR_LITERAL_ACC;
      end else if (w[13:8] == iomge_pkg::OPC_INC_FILE) begin
         op = iomge_pkg::IOMGE_OP_INCREMENT_FILE;
      end else if (w[13:8] == iomge_pkg::OPC_INC_SKIP) begin
         op = iomge_pkg::IOMGE_OP_INCREMENT_SKIP_ZERO;
      end else if (w[13:8] == iomge_pkg::OPC_OR_FILE) begin
         op = iomge_pkg::IOMGE_OP_OR_ACC_FILE;
      end else if (w[13:8] == iomge_pkg::OPC_MOVE_FILE) begin
         op = iomge_pkg::IOMGE_OP_MOVE_FILE;
      end
      return op;
   endfunction : decode

   // ==========================================================
   // operand class
   // true for the four ops that read a file register and route their
   // result by the destination bit; used by the write port and the
   // accumulator so both sides always agree on who gets the result
   function automatic logic is_file_op(input iomge_pkg::iomge_op_t o);
      logic hit;
      hit = 1'b0;
      unique case (o)
         iomge_pkg::IOMGE_OP_INCREMENT_FILE:      hit = 1'b1;
         iomge_pkg::IOMGE_OP_INCREMENT_SKIP_ZERO: hit = 1'b1;
         iomge_pkg::IOMGE_OP_OR_ACC_FILE:         hit = 1'b1;
         iomge_pkg::IOMGE_OP_MOVE_FILE:           hit = 1'b1;
         iomge_pkg::IOMGE_OP_OR_LITERAL_ACC:      hit = 1'b0;
         iomge_pkg::IOMGE_OP_JUMP_ABSOLUTE:       hit = 1'b0;
         iomge_pkg::IOMGE_OP_NONE:                hit = 1'b0;
         default:                                 hit = 1'b0;   // unused enum code
      endcase
      return hit;
   endfunction : is_file_op

   // ==========================================================
   // internal signals
   iomge_pkg::iomge_op_t op;
   logic                 take;
   logic                 jump_take;
   logic                 skip_hit;
   logic                 dest_file;
   logic [7:0]           result;
   logic                 result_zero;
   logic                 writes_zero;
   logic                 stall_d;

   assign insn_ready = !busy_q;                     // second cycle of skip or jump blocks fetch
   assign take       = insn_valid && insn_ready;
   assign op         = decode(insn_word);
   assign dest_file  = insn_word[iomge_pkg::DEST_BIT];
   assign file_raddr = insn_word[6:0];

   // strobes for the two instructions that need a second cycle;
   // the skip only stalls when the incremented value wraps to zero
   assign jump_take  = take && (op == iomge_pkg::IOMGE_OP_JUMP_ABSOLUTE);                      // [RQ3]
   assign skip_hit   = take && (op == iomge_pkg::IOMGE_OP_INCREMENT_SKIP_ZERO) && result_zero;  // [RQ1]

   // ==========================================================
   // result path
   // one shared 8-bit result for every op; the register file read is
   // combinational, so the result settles in the cycle the word is offered.
   // the increment wraps from ff to 00 on purpose: that wrap is what the
   // skip and the zero flag look for.
   always_comb begin
      result      = file_rdata;
      writes_zero = 1'b0;
      unique case (op)
         iomge_pkg::IOMGE_OP_INCREMENT_FILE: begin
            result      = file_rdata + iomge_pkg::BYTE_ONE;   // [RQ6]
            writes_zero = 1'b1;
         end
         iomge_pkg::IOMGE_OP_INCREMENT_SKIP_ZERO: begin
            result      = file_rdata + iomge_pkg::BYTE_ONE;   // [RQ1]
         end
         iomge_pkg::IOMGE_OP_OR_ACC_FILE: begin
            result      = acc_q | file_rdata;                 // [RQ7]
            writes_zero = 1'b1;
         end
         iomge_pkg::IOMGE_OP_MOVE_FILE: begin
            result      = file_rdata;                         // [RQ8]
            writes_zero = 1'b1;                               // [RQ9]
         end
         iomge_pkg::IOMGE_OP_OR_LITERAL_ACC: begin
            result      = acc_q | insn_word[7:0];             // [RQ5]
            writes_zero = 1'b1;
         end
         iomge_pkg::IOMGE_OP_JUMP_ABSOLUTE: begin
            result      = file_rdata;
         end
         iomge_pkg::IOMGE_OP_NONE: begin
            result      = file_rdata;
         end
      endcase
   end
   assign result_zero = (result == 8'h00);                    // [RQ10]

   // file-register write back for file-destination ops
   // the write strobe is qualified by take, so a word held off while busy
   // never writes twice; the file commits on the same edge as the accumulator
   always_comb begin
      file_we    = 1'b0;
      file_waddr = insn_word[6:0];
      file_wdata = result;
      if (take && dest_file && is_file_op(op)) begin
         file_we = 1'b1;                                      // [RQ2] [RQ6] [RQ7] [RQ8]
      end
   end

   // ==========================================================
   // accumulator
   // loaded by the literal or, or by a file op whose destination bit is
   // clear; jump, skip stall cycles and unknown words leave it unchanged
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         acc_q <= iomge_pkg::ACC_RST;
      end else if (take) begin
         if (op == iomge_pkg::IOMGE_OP_OR_LITERAL_ACC) begin
            acc_q <= result;                                  // [RQ5]
         end else if (!dest_file && is_file_op(op)) begin
            acc_q <= result;                                  // [RQ2] [RQ6] [RQ7] [RQ8]
         end
      end
   end

   // zero flag; skip and jump leave it alone
   // a move back to the same register still updates it, which is how
   // software tests a register for zero without touching the accumulator
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zero_flag_q <= 1'b0;
      end else if (take && writes_zero) begin
         zero_flag_q <= result_zero;                          // [RQ10] [RQ4]
      end
   end

   // ==========================================================
   // program counter and second-cycle stall
   // the dead cycle stands in for the discarded next word: a jump needs it
   // to refetch from the new target, a taken skip executes it as a no-op
   always_comb begin
      stall_d = 1'b0;
      if (jump_take) begin
         stall_d = 1'b1;                                      // [RQ4]
      end else if (skip_hit) begin
         stall_d = 1'b1;                                      // [RQ1]
      end
   end

   // busy lasts exactly one cycle: while it is high take is low, so
   // stall_d falls and the next edge clears it again
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= stall_d;                                   // [RQ10]
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         program_counter_q <= iomge_pkg::PCNT_RST;
      end else if (jump_take) begin
         // upper two bits come from the page latch, the rest from the word
         program_counter_q <= {page_latch[4:3], insn_word[10:0]};   // [RQ3]
      end else if (skip_hit) begin
         // step over the skipped word in one go
         program_counter_q <= program_counter_q + iomge_pkg::PCNT_ONE + iomge_pkg::PCNT_ONE;  // [RQ1]
      end else if (take) begin
         program_counter_q <= program_counter_q + iomge_pkg::PCNT_ONE;  // [RQ10]
      end
   end
endmodule : iomge_core
`default_nettype wire

// file: src/iomge_pkg.sv
// package: opcodes, field positions, widths and reset values for the execution block
`default_nettype none
package iomge_pkg;
   // ==========================================================
   // instruction word layout (14-bit)
   localparam int unsigned INSN_W      = 14;
   localparam int unsigned FADDR_W     = 7;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned PCNT_W      = 13;
   localparam int unsigned JUMP_W      = 11;
   localparam int unsigned DEST_BIT    = 7;
   localparam int unsigned PAGE_LO     = 3;
   // ==========================================================
   // opcode patterns
   localparam logic [5:0] OPC_INC_FILE  = 6'h0A;  // 00 1010 d fffffff
   localparam logic [5:0] OPC_INC_SKIP  = 6'h0F;  // 00 1111 d fffffff
   localparam logic [5:0] OPC_OR_FILE   = 6'h04;  // 00 0100 d fffffff
   localparam logic [5:0] OPC_MOVE_FILE = 6'h08;  // 00 1000 d fffffff
   localparam logic [5:0] OPC_OR_LIT    = 6'h38;  // 11 1000 kkkkkkkk
   localparam logic [2:0] OPC_JUMP      = 3'h5;   // 101 kkkkkkkkkkk
   // ==========================================================
   // reset values and step constants
   localparam logic [7:0]  ACC_RST     = 8'h00;
   localparam logic [12:0] PCNT_RST    = 13'h0000;
   localparam logic [7:0]  BYTE_ONE    = 8'h01;
   localparam logic [12:0] PCNT_ONE    = 13'h0001;
   // ==========================================================
   // decoded operation
   typedef enum logic [2:0] {
      IOMGE_OP_NONE,
      IOMGE_OP_INCREMENT_FILE,
      IOMGE_OP_INCREMENT_SKIP_ZERO,
      IOMGE_OP_OR_ACC_FILE,
      IOMGE_OP_MOVE_FILE,
      IOMGE_OP_OR_LITERAL_ACC,
      IOMGE_OP_JUMP_ABSOLUTE
   } iomge_op_t;
endpackage : iomge_pkg
`default_nettype wire

// file: test/iomge_core_chk.sv
// checker: timing and result assertions at the execution block ports
`default_nettype none
module iomge_core_chk (
   // clock, reset, handshake and flags
   input wire logic        ref_clk, rst, insn_valid, insn_ready, file_we, zero_flag_q, busy_q,
   // instruction, file port and state
   input wire logic [13:0] insn_word,
   input wire logic [6:0]  file_raddr, file_waddr,
   input wire logic [7:0]  file_rdata, file_wdata, page_latch, acc_q,
   input wire logic [12:0] program_counter_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // decode of the taken instruction
   wire       tk  = insn_valid && insn_ready;
   wire [5:0] op  = insn_word[13:8];
   wire       jmp = tk && insn_word[13:11] == iomge_pkg::OPC_JUMP;
   wire       isz = tk && op == iomge_pkg::OPC_INC_SKIP;
   wire       fop = tk && op inside {iomge_pkg::OPC_INC_FILE, iomge_pkg::OPC_OR_FILE, iomge_pkg::OPC_MOVE_FILE};
   wire       lit = tk && op == iomge_pkg::OPC_OR_LIT;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // one dead cycle, then ready again
   sequence s_stall;
      busy_q && !insn_ready ##1 insn_ready;
   endsequence
   chk_jump_target: assert property (jmp |=> program_counter_q == {$past(page_latch[4:3]), $past(insn_word[10:0])})
      else $error("jump target wrong");
   chk_jump_stall: assert property (jmp |=> s_stall)
      else $error("jump not two cycles");
   chk_jump_flags: assert property (jmp |=> $stable(zero_flag_q) && $stable(acc_q))
      else $error("jump changed state");
   chk_skip_taken: assert property (isz && file_rdata == 8'hFF |=> program_counter_q == $past(program_counter_q) + 13'h0002 ##0 s_stall)
      else $error("skip not taken");
   chk_skip_write: assert property (isz |-> file_we == insn_word[7] && file_wdata == file_rdata + 8'h01)
      else $error("skip result routing wrong");
   chk_file_zero: assert property (fop && insn_word[7] |-> file_we ##1 zero_flag_q == ($past(file_wdata) == 8'h00))
      else $error("zero flag wrong on file write");
   chk_acc_zero: assert property (fop && !insn_word[7] || lit |=> zero_flag_q == (acc_q == 8'h00))
      else $error("zero flag wrong on accumulator");
   chk_or_literal: assert property (lit |=> acc_q == ($past(acc_q) | $past(insn_word[7:0])))
      else $error("or literal wrong");
   chk_one_cycle: assert property (tk && !jmp && !(isz && file_rdata == 8'hFF) |=> insn_ready && program_counter_q == $past(program_counter_q) + 13'h0001)
      else $error("single cycle step wrong");
   chk_file_addr: assert property (tk |-> file_raddr == insn_word[6:0] && file_waddr == insn_word[6:0])
      else $error("file address wrong");
endmodule : iomge_core_chk
bind iomge_core iomge_core_chk i_chk (.ref_clk, .rst, .insn_valid, .insn_ready, .file_we, .zero_flag_q, .busy_q,
   .insn_word, .file_raddr, .file_waddr, .file_rdata, .file_wdata, .page_latch, .acc_q, .program_counter_q);
`default_nettype wire

// file: test/iomge_core_tb_top.sv
// testbench: directed and random instruction streams against a reference model
`default_nettype none
module iomge_core_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [7:0] acc; logic z; logic [12:0] pc; logic we; logic [7:0] wd;} iomge_exp_t;
   logic        ref_clk, rst, insn_valid, insn_ready, file_we, zero_flag_q, busy_q, m_z;
   logic [13:0] insn_word;
   logic [6:0]  file_raddr, file_waddr;
   logic [7:0]  file_rdata, file_wdata, page_latch, acc_q, m_acc, rf [128];
   logic [12:0] program_counter_q, m_pc;
   logic [31:0] seed = 32'h4026;
   int          err_total, cmp_count, cyc;
   iomge_exp_t  exp_q [$];
   assign file_rdata = rf[file_raddr];
   iomge_core i_iomge_core (.ref_clk, .rst, .insn_valid, .insn_word, .insn_ready, .file_raddr, .file_rdata,
      .file_we, .file_waddr, .file_wdata, .page_latch, .acc_q, .zero_flag_q, .program_counter_q, .busy_q);
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic cmp(input string n, input logic [12:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s exp %h got %h", n, e, g);
      end
   endtask : cmp
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   // offer one instruction and note its expected effect
   task automatic issue(input logic [13:0] w);
      logic [7:0] r;
      logic [5:0] op;
      logic       fo;
      while (insn_ready !== 1'b1) @(posedge ref_clk) #1;
      op = w[13:8];
      fo = op inside {iomge_pkg::OPC_INC_FILE, iomge_pkg::OPC_INC_SKIP, iomge_pkg::OPC_OR_FILE,
         iomge_pkg::OPC_MOVE_FILE};
      r = rf[w[6:0]];
      insn_word = w;
      insn_valid = 1'b1;
      if (op inside {iomge_pkg::OPC_INC_FILE, iomge_pkg::OPC_INC_SKIP}) r = r + 8'h01;
      if (op == iomge_pkg::OPC_OR_FILE) r = m_acc | r;
      if (op == iomge_pkg::OPC_OR_LIT) r = m_acc | w[7:0];
      if (fo && op != iomge_pkg::OPC_INC_SKIP || op == iomge_pkg::OPC_OR_LIT) m_z = r == 8'h00;
      if (fo && !w[7] || op == iomge_pkg::OPC_OR_LIT) m_acc = r;
      if (w[13:11] == iomge_pkg::OPC_JUMP) m_pc = {page_latch[4:3], w[10:0]};
      else m_pc = m_pc + (op == iomge_pkg::OPC_INC_SKIP && r == 8'h00 ? 13'h0002 : 13'h0001);
      exp_q.push_back('{m_acc, m_z, m_pc, fo && w[7], r});
      @(posedge ref_clk) #1;
   endtask : issue
   // clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // monitor: take the oldest note at each taken instruction
   always @(posedge ref_clk) begin
      iomge_exp_t e;
      cyc++;
      if (cyc == 1000) begin
         err_total++;
         results();
      end
      if (!rst && insn_valid && insn_ready) begin
         e = exp_q.pop_front();
         cmp("file_we", e.we, file_we);
         if (e.we) cmp("file_wdata", e.wd, file_wdata);
         if (file_we) rf[file_waddr] <= file_wdata;
         #1;
         cmp("acc", e.acc, acc_q);
         cmp("zero", e.z, zero_flag_q);
         cmp("pc", e.pc, program_counter_q);
      end
   end
   // main sequence: reset, directed cases, random stream
   initial begin
      logic [5:0]  ops [6];
      logic [13:0] dir [8];
      ops = '{iomge_pkg::OPC_INC_FILE, iomge_pkg::OPC_INC_SKIP, iomge_pkg::OPC_OR_FILE, iomge_pkg::OPC_MOVE_FILE,
         iomge_pkg::OPC_OR_LIT, {iomge_pkg::OPC_JUMP, 3'h3}};
      dir = '{14'h3800, 14'h0F85, 14'h0885, 14'h0A05, 14'h0F06, 14'h2FFF, 14'h38A5, 14'h0000};
      rst = 1'b1;
      insn_valid = 1'b0;
      insn_word = 14'h0000;
      page_latch = 8'h18;
      {m_acc, m_z, m_pc} = '0;
      for (int i = 0; i < 128; i++) begin
         seed = xs(seed);
         rf[i] = seed[7:0];
      end
      rf[5] = 8'hFF;
      rf[6] = 8'hFF;
      repeat (4) @(posedge ref_clk);
      #1 rst = 1'b0;
      foreach (dir[i]) issue(dir[i]);
      $display("directed stream done");
      for (int i = 0; i < 60; i++) begin
         seed = xs(seed);
         page_latch = seed[31:24];
         issue({ops[seed[2:0] % 6], seed[15:8]});
      end
      insn_valid = 1'b0;
      @(posedge ref_clk) #2;
      $display("random stream done");
      results();
   end
endmodule : iomge_core_tb_top
`default_nettype wire
